// ### scs_sequencer.sv
// start-up sequencer: strap capture, profile select, calibration,
// divider sync, lock wait, monitor enable and driver release
// assumes analog calibration/lock inputs and pins are asynchronous
`default_nettype none

module scs_sequencer
    import scs_pkg::*;
#(
    parameter int LOCK_LIMIT = LOCK_MAX_CYC,
    parameter int N_OUT      = 4
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // strap pins, asynchronous
    input  wire logic             status_pin_in,
    input  wire logic             oe_pin_in,
    input  wire logic             data_in_pin,
    input  wire logic             serial_out_pin_in,
    input  wire logic             select_n_pin,
    input  wire logic             serial_clk_pin,
    // strap-capable pin drivers
    input  wire logic             otp_load_done,
    input  wire logic             status_drive_val,
    input  wire logic             serial_out_drive_val,
    output var  logic             status_pin_out,
    output var  logic             status_pin_oe,
    output var  logic             serial_out_pin_out,
    output var  logic             serial_out_pin_oe,
    // configuration
    input  wire logic [3:0]       config_sel,
    input  wire logic [1:0]       i2c_addr_lo,
    input  wire logic             synth_mode,
    input  wire logic             fb_sync_en,
    input  wire logic [N_OUT-1:0] out_en_mask,
    // commands, one-cycle pulses
    input  wire logic             divider_sync_cmd,
    input  wire logic             pll_restart_cmd,
    // analog handshake, asynchronous
    input  wire logic             vco_cal_done,
    input  wire logic             pll_lock,
    output var  logic             vco_cal_req,
    output var  logic             vco_gate,
    output var  logic             out_div_rst,
    output var  logic             fb_div_rst,
    output var  logic             ref_mon_en,
    output var  logic [N_OUT-1:0] out_drv_en,
    // status
    output var  scs_strap_t       strap_levels,
    output var  scs_profile_t     profile,
    output var  logic             startup_done,
    output var  logic             lock_late,
    // register address decode
    input  wire logic [15:0]      reg_addr,
    output var  scs_block_t       reg_blk,
    output var  logic [1:0]       reg_out_idx,
    output var  logic [7:0]       reg_offset
);

    localparam int NSYNC = 8;
    localparam int CW    = $clog2(LOCK_LIMIT + 1);

    typedef enum logic [9:0] {
        ST_RESET   = 10'h001,
        ST_STRAP   = 10'h002,
        ST_CAL     = 10'h004,
        ST_GATE    = 10'h008,
        ST_RELEASE = 10'h010,
        ST_UNGATE  = 10'h020,
        ST_LOCK    = 10'h040,
        ST_MON     = 10'h080,
        ST_DRV     = 10'h100,
        ST_DONE    = 10'h200
    } scs_state_t;

    scs_state_t       state;
    scs_state_t       next_state;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] filt;
    logic [2:0]       strap_cnt;
    logic             sclk_latched;
    logic [CW-1:0]    lock_cnt;
    logic             first_pass;
    scs_strap_t       strap_f;
    logic             cal_done_f;
    logic             lock_f;
    scs_profile_t     next_profile;
    scs_block_t       dec_blk;
    logic [1:0]       dec_idx;
    logic [7:0]       dec_off;

    function automatic scs_profile_t select_profile(
        input logic [3:0] sel,
        input scs_strap_t s,
        input logic       sclk,
        input logic [1:0] ia
    );
        scs_profile_t p;
        p = '0;
        if (sel <= SEL_DIRECT_MAX)
            p = {sel[1:0], ia};
        else
        begin
            case (sel)
                SEL_DEFAULT:    p = {s.oe, s.status, s.select_n, s.serial_out};
                4'h5:           p = {s.serial_out, s.status, s.select_n, s.oe};
                4'h6:           p = {s.serial_out, s.oe, s.select_n, s.status};
                SEL_ADDR_FIELD: p = {s.data_in, sclk, ia};
                4'h8:           p = {s.select_n, s.status, s.serial_out, s.oe};
                4'h9:           p = {s.select_n, s.oe, s.serial_out, s.status};
                4'ha:           p = {s.select_n, s.serial_out, s.oe, s.status};
                4'hb:           p = {s.select_n, s.data_in, s.serial_out, s.status};
                4'hc:           p = {s.select_n, sclk, s.oe, s.data_in};
                4'hd:           p = {s.select_n, s.data_in, s.oe, sclk};
                4'he:           p = {s.data_in, s.status, s.oe, s.select_n};
                default:        p = {s.data_in, s.serial_out, s.oe, s.status};
            endcase
        end
        return p;
    endfunction

    // three-stage input synchronisers with agreement filter
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            filt  <= '0;
        end
        else
        begin
            sync1 <= {pll_lock, vco_cal_done, serial_clk_pin, status_pin_in, oe_pin_in,
                      data_in_pin, serial_out_pin_in, select_n_pin};
            sync2 <= sync1;
            sync3 <= sync2;
            filt  <= (filt & ~(sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
        end
    end

    assign strap_f    = filt[4:0];
    assign lock_f     = filt[7];
    assign cal_done_f = filt[6];

    // sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RESET:   next_state = ST_STRAP;
            ST_STRAP:   if (strap_cnt == STRAP_SETTLE) next_state = ST_CAL;
            ST_CAL:     if (cal_done_f) next_state = ST_GATE;
            ST_GATE:    next_state = ST_RELEASE;
            ST_RELEASE: next_state = ST_UNGATE;
            ST_UNGATE:  next_state = ST_LOCK;
            // a stale lock must flush out of the synchronisers first
            ST_LOCK:    if (lock_f && strap_cnt == STRAP_SETTLE) next_state = ST_MON;
            ST_MON:     next_state = ST_DRV;
            ST_DRV:     next_state = ST_DONE;
            default:    next_state = state;
        endcase
        // restart commands once straps are taken
        if (state != ST_RESET && state != ST_STRAP)
        begin
            if (pll_restart_cmd)
                next_state = ST_CAL;
            else if (divider_sync_cmd)
                next_state = ST_GATE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // strap capture after synchronisers settle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            strap_cnt    <= 3'h0;
            strap_levels <= '0;
            sclk_latched <= 1'b0;
        end
        else
        begin
            // restarts on each state change, also times the lock settle
            if (next_state != state)
                strap_cnt <= 3'h0;
            else if (strap_cnt != STRAP_SETTLE)
                strap_cnt <= strap_cnt + 3'h1;
            if (state == ST_STRAP && strap_cnt == STRAP_SETTLE)
            begin
                strap_levels <= strap_f;
                sclk_latched <= filt[5];
            end
        end
    end

    assign next_profile = select_profile(config_sel, strap_levels, sclk_latched,
                                         i2c_addr_lo);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            profile <= '0;
        else
            profile <= next_profile;
    end

    // analog and divider controls follow the next state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            vco_cal_req <= 1'b0;
            vco_gate    <= 1'b0;
            out_div_rst <= 1'b1;
            fb_div_rst  <= 1'b1;
            first_pass  <= 1'b1;
        end
        else
        begin
            vco_cal_req <= (next_state == ST_CAL);
            // gate, release, ungate so output dividers start together; feedback divider too on first pass or with fb_sync_en
            vco_gate <= (next_state == ST_GATE) || (next_state == ST_RELEASE);
            if (next_state == ST_GATE)
            begin
                out_div_rst <= 1'b1;
                fb_div_rst  <= fb_sync_en || first_pass;
            end
            else if (next_state == ST_RELEASE)
            begin
                out_div_rst <= 1'b0;
                fb_div_rst  <= 1'b0;
            end
            if (next_state == ST_DONE)
                first_pass <= 1'b0;
        end
    end

    // monitors, drivers and completion
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ref_mon_en   <= 1'b0;
            out_drv_en   <= '0;
            startup_done <= 1'b0;
        end
        else
        begin
            ref_mon_en   <= (next_state == ST_MON) || (next_state == ST_DRV) ||
                            (next_state == ST_DONE);
            startup_done <= (next_state == ST_DONE);
            if ((next_state == ST_DRV || next_state == ST_DONE) && synth_mode)
                out_drv_en <= out_en_mask;
            else
                out_drv_en <= '0;
        end
    end

    // start-up time watchdog
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lock_cnt  <= '0;
            lock_late <= 1'b0;
        end
        else if (first_pass && state != ST_DONE)
        begin
            if (lock_cnt == CW'(LOCK_LIMIT))
                lock_late <= 1'b1;
            else
                lock_cnt <= lock_cnt + CW'(1);
        end
    end

    // strap-capable pins stay undriven until configuration load
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            status_pin_oe      <= 1'b0;
            serial_out_pin_oe  <= 1'b0;
            status_pin_out     <= 1'b0;
            serial_out_pin_out <= 1'b0;
        end
        else
        begin
            status_pin_oe      <= otp_load_done;
            serial_out_pin_oe  <= otp_load_done;
            status_pin_out     <= status_drive_val;
            serial_out_pin_out <= serial_out_drive_val;
        end
    end

    scs_block_decode u_decode (
        .addr    (reg_addr),
        .blk     (dec_blk),
        .out_idx (dec_idx),
        .offset  (dec_off)
    );

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_blk     <= BLK_NONE;
            reg_out_idx <= 2'h0;
            reg_offset  <= 8'h00;
        end
        else
        begin
            reg_blk     <= dec_blk;
            reg_out_idx <= dec_idx;
            reg_offset  <= dec_off;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_gate_release_order: assert property ($fell(out_div_rst) |-> vco_gate ##1 !vco_gate)
        else $error("divider release not inside gated window");
    chk_ungate_after_rst: assert property ($fell(vco_gate) |-> !out_div_rst && $past(!out_div_rst))
        else $error("ungated before divider reset released");
    chk_monitor_lock: assert property ($rose(ref_mon_en) |-> $past(lock_f))
        else $error("monitors enabled without lock");
    chk_done_drivers: assert property ($rose(startup_done) && synth_mode |-> $past(out_drv_en) == out_en_mask)
        else $error("start-up done before drivers enabled");
    chk_sync_drv_off: assert property (divider_sync_cmd && !pll_restart_cmd && state == ST_DONE |=> state == ST_GATE ##0 (out_drv_en == '0) [*4])
        else $error("drivers active during divider sync");
    chk_restart_cal: assert property (pll_restart_cmd && state == ST_DONE |=> state == ST_CAL && out_drv_en == '0 && !ref_mon_en)
        else $error("restart did not return to calibration");
    chk_strap_latch: assert property (state == ST_STRAP && strap_cnt == STRAP_SETTLE |=> strap_levels == $past(strap_f))
        else $error("strap levels not latched");
    chk_profile_map: assert property (config_sel <= SEL_DIRECT_MAX ##1 $stable(config_sel) && $stable(i2c_addr_lo) |=> profile == {$past(config_sel[1:0], 2), $past(i2c_addr_lo, 2)})
        else $error("direct profile mismatch");
    chk_straps_quiet: assert property (!$past(otp_load_done) |-> !status_pin_oe && !serial_out_pin_oe)
        else $error("strap pin driven before configuration load");

    cov_startup: cover property ($rose(startup_done));
    cov_div_sync: cover property (state == ST_DONE && divider_sync_cmd ##1 state == ST_GATE);
    cov_restart: cover property (state == ST_DONE && pll_restart_cmd ##1 state == ST_CAL);
    cov_late: cover property ($rose(lock_late));

endmodule

`default_nettype wire

// ### scs_pkg.sv
// shared constants and types for the start-up and configuration sequencer
// assumes a single 10 MHz system clock and a synchronous active-high reset
`default_nettype none

package scs_pkg;

    // clock and timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int LOCK_TYP_US  = 200;
    localparam int LOCK_MAX_MS  = 10;
    localparam int LOCK_MAX_CYC = LOCK_MAX_MS * (CLK_HZ / 1000);

    // strap capture settle count after reset release
    localparam logic [2:0] STRAP_SETTLE = 3'h4;

    // profile selection codes with special meaning
    localparam logic [3:0] SEL_DIRECT_MAX = 4'h3;
    localparam logic [3:0] SEL_DEFAULT    = 4'h4;
    localparam logic [3:0] SEL_ADDR_FIELD = 4'h7;

    // register block bases
    localparam logic [15:0] BASE_GLOBAL = 16'h0000;
    localparam logic [15:0] BASE_INT    = 16'h0020;
    localparam logic [15:0] BASE_INT_END = 16'h0030;
    localparam logic [15:0] BASE_LOSMON = 16'h0050;
    localparam logic [15:0] BASE_LOS_END = 16'h0060;
    localparam logic [15:0] BASE_MISC   = 16'h00a0;
    localparam logic [15:0] BASE_MISC_END = 16'h00e0;
    localparam logic [15:0] BASE_SYSDIV = 16'h00f0;
    localparam logic [15:0] BASE_SYSDIV_END = 16'h00f4;
    localparam logic [15:0] BASE_OUT    = 16'h0100;
    localparam logic [15:0] BASE_REF    = 16'h0120;
    localparam logic [15:0] BASE_REF_END = 16'h0124;
    localparam logic [15:0] BASE_GPIO   = 16'h0130;
    localparam logic [15:0] BASE_SSI    = 16'h0140;
    localparam logic [15:0] BASE_APLL   = 16'h0150;
    localparam logic [15:0] BASE_INP    = 16'h0190;
    localparam logic [15:0] BASE_INP_END = 16'h01d0;

    // clock output blocks repeat every stride
    localparam logic [15:0] OUT_STRIDE   = 16'h0008;
    localparam int          OUT_IDX_LSB  = 3;

    typedef enum logic [3:0] {
        BLK_NONE   = 4'h0,
        BLK_GLOBAL = 4'h1,
        BLK_INT    = 4'h2,
        BLK_LOSMON = 4'h3,
        BLK_MISC   = 4'h4,
        BLK_SYSDIV = 4'h5,
        BLK_OUT    = 4'h6,
        BLK_REF    = 4'h7,
        BLK_GPIO   = 4'h8,
        BLK_SSI    = 4'h9,
        BLK_APLL   = 4'ha,
        BLK_INP    = 4'hb
    } scs_block_t;

    // pin levels latched at reset release
    typedef struct packed {
        logic status;
        logic oe;
        logic data_in;
        logic serial_out;
        logic select_n;
    } scs_strap_t;

    // selected configuration index and low target address bits
    typedef struct packed {
        logic [1:0] cfg_idx;
        logic [1:0] addr_lo;
    } scs_profile_t;

endpackage

`default_nettype wire

// ### scs_block_decode.sv
// register address decoder placing function blocks at fixed bases
// assumes a 16-bit register address from the serial port; purely combinational
`default_nettype none

module scs_block_decode
    import scs_pkg::*;
(
    // address in
    input  wire logic [15:0] addr,
    // decoded block
    output var  scs_block_t  blk,
    output var  logic [1:0]  out_idx,
    output var  logic [7:0]  offset
);

    function automatic logic [7:0] rel(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] d;
        d = a - b;
        return d[7:0];
    endfunction

    always_comb
    begin
        blk     = BLK_NONE;
        out_idx = 2'h0;
        offset  = 8'h00;
        if (addr < BASE_INT)
        begin
            blk    = BLK_GLOBAL;
            offset = rel(addr, BASE_GLOBAL);
        end
        else if (addr < BASE_INT_END)
        begin
            blk    = BLK_INT;
            offset = rel(addr, BASE_INT);
        end
        else if (addr >= BASE_LOSMON && addr < BASE_LOS_END)
        begin
            blk    = BLK_LOSMON;
            offset = rel(addr, BASE_LOSMON);
        end
        else if (addr >= BASE_MISC && addr < BASE_MISC_END)
        begin
            blk    = BLK_MISC;
            offset = rel(addr, BASE_MISC);
        end
        else if (addr >= BASE_SYSDIV && addr < BASE_SYSDIV_END)
        begin
            blk    = BLK_SYSDIV;
            offset = rel(addr, BASE_SYSDIV);
        end
        else if (addr >= BASE_OUT && addr < BASE_REF)
        begin
            // four identical layouts, one per output
            blk     = BLK_OUT;
            out_idx = addr[OUT_IDX_LSB+1:OUT_IDX_LSB];
            offset  = rel(addr, BASE_OUT) & (OUT_STRIDE[7:0] - 8'h01);
        end
        else if (addr >= BASE_REF && addr < BASE_REF_END)
        begin
            blk    = BLK_REF;
            offset = rel(addr, BASE_REF);
        end
        else if (addr >= BASE_GPIO && addr < BASE_SSI)
        begin
            blk    = BLK_GPIO;
            offset = rel(addr, BASE_GPIO);
        end
        else if (addr >= BASE_SSI && addr < BASE_APLL)
        begin
            blk    = BLK_SSI;
            offset = rel(addr, BASE_SSI);
        end
        else if (addr >= BASE_APLL && addr < BASE_INP)
        begin
            blk    = BLK_APLL;
            offset = rel(addr, BASE_APLL);
        end
        else if (addr >= BASE_INP && addr < BASE_INP_END)
        begin
            blk    = BLK_INP;
            offset = rel(addr, BASE_INP);
        end
    end

endmodule

`default_nettype wire

// ### scs_analog_model.sv
// behavioural model of the analog side: vco calibration and pll lock
// assumes requests come from the sequencer on the same system clock
`default_nettype none

module scs_analog_model
#(
    parameter int CAL_DLY  = 6,
    parameter int LOCK_DLY = 20,
    parameter int SLOW_DLY = 300
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // requests from the sequencer
    input  wire logic vco_cal_req,
    input  wire logic vco_gate,
    input  wire logic slow,
    // analog answers
    output var  logic vco_cal_done,
    output var  logic pll_lock
);
    timeunit 1ns;
    timeprecision 1ns;

    int cal_cnt;
    int lk_cnt;

    // calibration answers only while requested
    always_ff @(posedge clk)
    begin
        if (sys_rst || !vco_cal_req)
        begin
            cal_cnt      <= 0;
            vco_cal_done <= 1'b0;
        end
        else if (cal_cnt == CAL_DLY)
            vco_cal_done <= 1'b1;
        else
            cal_cnt <= cal_cnt + 1;
    end

    // lock is lost while calibrating or gated, slow mode locks late
    always_ff @(posedge clk)
    begin
        if (sys_rst || vco_cal_req || vco_gate)
        begin
            lk_cnt   <= 0;
            pll_lock <= 1'b0;
        end
        else if (lk_cnt == (slow ? SLOW_DLY : LOCK_DLY))
            pll_lock <= 1'b1;
        else
            lk_cnt <= lk_cnt + 1;
    end

endmodule

`default_nettype wire

// ### scs_sequencer_tb.sv
// testbench for the start-up sequencer, profile select and address decode
// assumes the analog model answers calibration and lock requests
`default_nettype none

module scs_sequencer_tb
    import scs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, sys_rst, slow, otp_load_done, status_drive_val, serial_out_drive_val;
    logic status_pin_in, oe_pin_in, data_in_pin, serial_out_pin_in, select_n_pin;
    logic serial_clk_pin, synth_mode, fb_sync_en, divider_sync_cmd, pll_restart_cmd;
    logic vco_cal_done, pll_lock, vco_cal_req, vco_gate, out_div_rst, fb_div_rst;
    logic status_pin_out, status_pin_oe, serial_out_pin_out, serial_out_pin_oe;
    logic ref_mon_en, startup_done, lock_late;
    logic [3:0]   config_sel, out_en_mask, out_drv_en;
    logic [1:0]   i2c_addr_lo, reg_out_idx;
    logic [15:0]  reg_addr;
    logic [7:0]   reg_offset;
    scs_block_t   reg_blk;
    scs_strap_t   strap_levels;
    scs_profile_t profile;
    int           error_cnt;
    int           comparisons;

    scs_sequencer #(.LOCK_LIMIT(200), .N_OUT(4)) i_dut (.*);
    scs_analog_model i_ana (.clk(clk), .sys_rst(sys_rst), .vco_cal_req(vco_cal_req),
        .vco_gate(vco_gate), .slow(slow), .vco_cal_done(vco_cal_done), .pll_lock(pll_lock));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #10;
    endtask

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wait_on(input int which);
        logic hit;
        for (int i = 0; i < 1000; i++)
        begin
            tick();
            case (which)
                0: hit = vco_cal_req;
                1: hit = vco_gate;
                2: hit = ref_mon_en;
                default: hit = startup_done;
            endcase
            if (hit === 1'b1)
                return;
        end
        error_cnt++;
        $display("Error %0t: wait %0d timed out", $time, which);
        results();
    endtask

    task automatic do_reset(input scs_strap_t s, input logic sc, input logic sl);
        sys_rst = 1'b1;
        otp_load_done = 1'b0;
        {status_pin_in, oe_pin_in, data_in_pin, serial_out_pin_in, select_n_pin} = s;
        serial_clk_pin = sc;
        slow = sl;
        repeat (5) tick();
        sys_rst = 1'b0;
    endtask

    // expected {cfg_idx, addr_lo} per selection code
    function automatic logic [3:0] exp_prof(input logic [3:0] sel, input scs_strap_t s,
                                            input logic c, input logic [1:0] ia);
        logic l, o, d, q, n;
        {l, o, d, q, n} = s;
        case (sel)
            4'h4: return {o, l, n, q};
            4'h5: return {q, l, n, o};
            4'h6: return {q, o, n, l};
            4'h7: return {d, c, ia};
            4'h8: return {n, l, q, o};
            4'h9: return {n, o, q, l};
            4'ha: return {n, q, o, l};
            4'hb: return {n, d, q, l};
            4'hc: return {n, c, o, d};
            4'hd: return {n, d, o, c};
            4'he: return {d, l, o, n};
            4'hf: return {d, q, o, l};
            default: return {sel[1:0], ia};
        endcase
    endfunction

    task automatic prof_sweep(input scs_strap_t s, input logic c);
        for (int k = 0; k < 16; k++)
        begin
            config_sel = k[3:0];
            tick();
            tick();
            check(profile, exp_prof(k[3:0], s, c, i2c_addr_lo), "profile");
        end
        config_sel = SEL_DEFAULT;
    endtask

    logic [15:0] dec_a[15] = '{16'h0000, 16'h0022, 16'h0030, 16'h005c, 16'h00a3,
        16'h00f0, 16'h010d, 16'h0118, 16'h0121, 16'h0124, 16'h0135, 16'h0140,
        16'h0160, 16'h01cf, 16'h01d0};
    // {blk, out index, offset}
    logic [13:0] dec_e[15] = '{14'h0400, 14'h0802, 14'h0000, 14'h0c0c, 14'h1003,
        14'h1400, 14'h1905, 14'h1b00, 14'h1c01, 14'h0000, 14'h2005, 14'h2400,
        14'h2810, 14'h2c3f, 14'h0000};

    initial
    begin
        {otp_load_done, status_drive_val, serial_out_drive_val, divider_sync_cmd} = '0;
        {pll_restart_cmd, fb_sync_en, slow} = '0;
        synth_mode = 1'b1;
        config_sel = SEL_DEFAULT;
        i2c_addr_lo = 2'h2;
        out_en_mask = 4'hb;
        reg_addr = 16'h0000;
        do_reset(5'h15, 1'b1, 1'b0);
        check({out_div_rst, fb_div_rst, vco_cal_req, vco_gate, ref_mon_en}, 5'h18, "rst");
        check({status_pin_oe, serial_out_pin_oe, out_drv_en, startup_done}, 0, "rst");
        wait_on(0);
        check(strap_levels, 5'h15, "straps");
        wait_on(1);
        check({vco_cal_req, out_div_rst, fb_div_rst, ref_mon_en}, 4'h6, "gate");
        tick();
        check({vco_gate, out_div_rst, fb_div_rst}, 3'h4, "release");
        tick();
        check(vco_gate, 1'b0, "ungate");
        wait_on(2);
        check({pll_lock, out_drv_en}, 5'h10, "monitors");
        tick();
        check(out_drv_en, out_en_mask, "drivers");
        wait_on(3);
        check(lock_late, 1'b0, "late");
        $display("test startup done");
        otp_load_done = 1'b1;
        status_drive_val = 1'b1;
        tick();
        tick();
        check({status_pin_oe, serial_out_pin_oe, status_pin_out, serial_out_pin_out},
              4'he, "pins");
        prof_sweep(5'h15, 1'b1);
        for (int k = 0; k < 15; k++)
        begin
            reg_addr = dec_a[k];
            tick();
            check({reg_blk, reg_out_idx, reg_offset}, dec_e[k], "decode");
        end
        $display("test straps and decode done");
        for (int k = 0; k < 2; k++)
        begin
            fb_sync_en = k[0];
            divider_sync_cmd = 1'b1;
            tick();
            divider_sync_cmd = 1'b0;
            check({vco_gate, out_div_rst, fb_div_rst}, {2'h3, k[0]}, "sync");
            check({out_drv_en, ref_mon_en, startup_done}, 0, "sync off");
            wait_on(3);
            check({pll_lock, out_drv_en}, {1'b1, out_en_mask}, "sync back");
        end
        pll_restart_cmd = 1'b1;
        tick();
        pll_restart_cmd = 1'b0;
        check({vco_cal_req, out_drv_en, ref_mon_en}, 6'h20, "restart");
        wait_on(3);
        check(out_drv_en, out_en_mask, "restart back");
        $display("test commands done");
        synth_mode = 1'b0;
        config_sel = 4'h8;
        do_reset(5'h0a, 1'b0, 1'b0);
        wait_on(3);
        check(out_drv_en, 4'h0, "not synth");
        prof_sweep(5'h0a, 1'b0);
        $display("test dco straps done");
        synth_mode = 1'b1;
        do_reset(5'h15, 1'b1, 1'b1);
        wait_on(3);
        check(lock_late, 1'b1, "late");
        $display("test late lock done");
        results();
    end

endmodule

`default_nettype wire
